/* File: hw/tag_regs_cfg.svh */
// register offsets, field positions, reset values and timing counts for the tag registers
`ifndef TAG_REGS_CFG_SVH
`define TAG_REGS_CFG_SVH
`define ORIG_TAG_OFFSET 12'h000
`define BYP_TAG_OFFSET 12'h004
`define IDCAP_OFFSET 12'h008
`define STATUS_OFFSET 12'h00C
`define UPDATE_BIT 31
`define GROUP_MSB 23
`define GROUP_LSB 16
`define PART_MSB 15
`define PART_LSB 0
`define TAG_RESET 32'h0000_0000
`define UPDATE_LAT 2
`endif

/* File: hw/tag_regs_pkg.sv */
// types shared by the tag register bank
package tag_regs_pkg;
  typedef logic [7:0] group_id_t;
  typedef logic [15:0] part_id_t;
  typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT, UPD_APPLY} upd_state_t;
endpackage : tag_regs_pkg

/* File: hw/tag_update_if.sv */
// handshake between the register bank and one tag update engine
`timescale 1ns/1ps
interface tag_update_if;
  logic start;
  logic [23:0] value;
  logic busy;
  logic [23:0] active;
  modport bank (output start, output value, input busy, input active);
  modport engine (input start, input value, output busy, output active);
endinterface : tag_update_if

/* File: hw/tag_update_engine.sv */
// applies a new tag value to traffic after a fixed delay and reports completion
`timescale 1ns/1ps
`include "tag_regs_cfg.svh"
module tag_update_engine
  import tag_regs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  tag_update_if.engine upd
);
  upd_state_t state_reg;
  upd_state_t state_next;
  logic [1:0] cnt_reg;
  logic [23:0] pend_reg;
  logic [23:0] active_reg;
  wire cnt_done = (cnt_reg == 2'(`UPDATE_LAT - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      UPD_IDLE: if (upd.start) state_next = UPD_WAIT;
      UPD_WAIT: if (cnt_done) state_next = UPD_APPLY;
      UPD_APPLY: state_next = UPD_IDLE;
      default: state_next = UPD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= UPD_IDLE;
      cnt_reg <= 2'h0;
      pend_reg <= 24'h000000;
      active_reg <= 24'h000000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= (state_reg == UPD_WAIT) ? cnt_reg + 2'h1 : 2'h0;
      // a start while busy is ignored: the earlier value completes
      if (state_reg == UPD_IDLE && upd.start) pend_reg <= upd.value;
      if (state_reg == UPD_APPLY) active_reg <= pend_reg;
    end
  end

  assign upd.busy = (state_reg != UPD_IDLE);
  assign upd.active = active_reg;
endmodule : tag_update_engine

/* File: hw/partition_id_update_regs.sv */
// apb register bank holding the originated-access and bypass partition tags
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "tag_regs_cfg.svh"
module partition_id_update_regs
  import tag_regs_pkg::*;
#(
  parameter group_id_t MAX_GROUP = 8'h0F,
  parameter part_id_t MAX_PART = 16'h0034
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // client transaction qualifiers
  input wire logic translation_enable_in,
  input wire logic ats_translated_in,
  input wire logic ats_check_setting_in,
  input wire logic nonsecure_in,
  input wire logic [7:0] stream_group_id_in,
  input wire logic [15:0] stream_partition_id_in,
  output logic [7:0] originated_group_id_out,
  output logic [15:0] originated_partition_id_out,
  output logic [7:0] client_group_id_out,
  output logic [15:0] client_partition_id_out,
  output logic client_bypass_out
);
  // ----------------------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------------------
  // a bank that supports neither id kind has nothing to tag traffic with
  if (MAX_PART == 16'h0000 && MAX_GROUP == 8'h00) begin : g_no_ids
    $error("no id support configured");
  end
  // the engine counts the update latency in two bits
  if (`UPDATE_LAT < 1 || `UPDATE_LAT > 4) begin : g_bad_lat
    $error("update latency out of the engine counter range");
  end

  // ----------------------------------------------------------------------------
  // supported widths and masks
  // ----------------------------------------------------------------------------
  function automatic logic [15:0] width_mask(input logic [15:0] maxv);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      if (maxv[i]) m = 16'((32'h1 << (i + 1)) - 1);
    end
    return m;
  endfunction : width_mask

  localparam logic [15:0] PART_MASK = width_mask(MAX_PART);
  localparam logic [15:0] GROUP_MASK16 = width_mask({8'h00, MAX_GROUP});
  localparam logic [7:0] GROUP_MASK = GROUP_MASK16[7:0];

  function automatic logic [23:0] clean_ids(input logic [31:0] d);
    return {d[`GROUP_MSB:`GROUP_LSB] & GROUP_MASK, d[`PART_MSB:`PART_LSB] & PART_MASK};
  endfunction : clean_ids

  // ----------------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------------
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire sel_orig = (paddr == `ORIG_TAG_OFFSET);
  wire sel_byp = (paddr == `BYP_TAG_OFFSET);
  wire sel_cap = (paddr == `IDCAP_OFFSET);
  wire sel_stat = (paddr == `STATUS_OFFSET);
  wire mapped = sel_orig || sel_byp || sel_cap || sel_stat;

  logic [23:0] orig_ids_reg;
  logic [23:0] byp_ids_reg;
  logic ready_reg;

  tag_update_if orig_if ();
  tag_update_if byp_if ();

  // a correct update carries the flag and arrives while idle
  wire flag_set = pwdata[`UPDATE_BIT];
  wire orig_upd = wr && sel_orig && flag_set && !orig_if.busy && ready_reg;
  wire byp_upd = wr && sel_byp && flag_set && !byp_if.busy && ready_reg;

  assign orig_if.start = orig_upd;
  assign orig_if.value = clean_ids(pwdata);
  assign byp_if.start = byp_upd;
  assign byp_if.value = clean_ids(pwdata);

  tag_update_engine u_orig (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .upd(orig_if)
  );

  tag_update_engine u_byp (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .upd(byp_if)
  );

  // ----------------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------------
  logic [31:0] rdata;
  always_comb begin
    if (sel_orig) begin
      rdata = {orig_if.busy, 7'h00, orig_ids_reg};
    end else if (sel_byp) begin
      rdata = {byp_if.busy, 7'h00, byp_ids_reg};
    end else if (sel_cap) begin
      rdata = {8'h00, MAX_GROUP, MAX_PART};
    end else if (sel_stat) begin
      rdata = {30'h0, byp_if.busy, orig_if.busy};
    end else begin
      rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------------
  // registers: one wait state per access keeps pready a flop
  // ----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      orig_ids_reg <= 24'h000000;
      byp_ids_reg <= 24'h000000;
      ready_reg <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      // writes without the flag, or during a pending update, are dropped
      if (orig_upd) orig_ids_reg <= orig_if.value;
      if (byp_upd) byp_ids_reg <= byp_if.value;
      ready_reg <= acc && !ready_reg;
      prdata <= (acc && !ready_reg && !pwrite) ? rdata : 32'h0000_0000;
      pslverr <= acc && !ready_reg && !mapped;
    end
  end
  assign pready = ready_reg;

  // ----------------------------------------------------------------------------
  // traffic tagging
  // ----------------------------------------------------------------------------
  // ids are masked to the bit width of the maximum, so values above it within that width pass, which is one permitted arbitrary id
  wire use_bypass = nonsecure_in &&
    (!translation_enable_in || (ats_translated_in && !ats_check_setting_in));
  wire [23:0] client_ids = use_bypass ? byp_if.active
                                      : {stream_group_id_in, stream_partition_id_in};

  // originated tags feed table fetch, queue and interrupt-write masters
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      originated_group_id_out <= 8'h00;
      originated_partition_id_out <= 16'h0000;
      client_group_id_out <= 8'h00;
      client_partition_id_out <= 16'h0000;
      client_bypass_out <= 1'b0;
    end else begin
      originated_group_id_out <= orig_if.active[23:16];
      originated_partition_id_out <= orig_if.active[15:0];
      client_group_id_out <= client_ids[23:16];
      client_partition_id_out <= client_ids[15:0];
      client_bypass_out <= use_bypass;
    end
  end

  // ----------------------------------------------------------------------------
  // helper state for the checks
  // ----------------------------------------------------------------------------
  // how long each update flag has stood, and what each engine last accepted
  logic [3:0] orig_busy_cnt_reg;
  logic [3:0] byp_busy_cnt_reg;
  logic [23:0] orig_taken_reg;
  logic [23:0] byp_taken_reg;
  // the flag stands for the wait cycles and the apply cycle
  localparam logic [3:0] BUSY_MAX = 4'(`UPDATE_LAT + 1);
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      orig_busy_cnt_reg <= 4'h0;
      byp_busy_cnt_reg <= 4'h0;
      orig_taken_reg <= 24'h000000;
      byp_taken_reg <= 24'h000000;
    end else begin
      orig_busy_cnt_reg <= orig_if.busy ? orig_busy_cnt_reg + 4'h1 : 4'h0;
      byp_busy_cnt_reg <= byp_if.busy ? byp_busy_cnt_reg + 4'h1 : 4'h0;
      if (orig_upd) orig_taken_reg <= orig_if.value;
      if (byp_upd) byp_taken_reg <= byp_if.value;
    end
  end

  // ----------------------------------------------------------------------------
  // checks: bus timing
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);

  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");

  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("error response without pready");

  prdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside the ready cycle");

  cap_read_a: assert property (acc && !pready && !pwrite && sel_cap |=>
      prdata == {8'h00, MAX_GROUP, MAX_PART})
    else $error("capability word wrong");

  unmapped_quiet_a: assert property (wr && !mapped |=>
      $stable(orig_ids_reg) && $stable(byp_ids_reg))
    else $error("unmapped write changed a register");

  ro_write_quiet_a: assert property (wr && (sel_cap || sel_stat) |=>
      $stable(orig_ids_reg) && $stable(byp_ids_reg))
    else $error("read-only write changed a register");

  orig_word_read_a: assert property (acc && !pready && !pwrite && sel_orig |=>
      prdata[23:0] == $past(orig_ids_reg))
    else $error("originated word read back wrong");

  upper_zero_a: assert property (acc && !pready && !pwrite && (sel_orig || sel_byp) |=>
      prdata[30:24] == 7'h00)
    else $error("unused tag bits read nonzero");

  stat_read_a: assert property (acc && !pready && !pwrite && sel_stat |=>
      prdata[1:0] == $past({byp_if.busy, orig_if.busy}))
    else $error("status word wrong");

  // ----------------------------------------------------------------------------
  // checks: update handshake
  // ----------------------------------------------------------------------------

  upd_flag_clears_a: assert property (orig_upd |=> orig_if.busy [*3] ##1 !orig_if.busy)
    else $error("originated update flag timing wrong");

  byp_flag_clears_a: assert property (byp_upd |=> byp_if.busy [*3] ##1 !byp_if.busy)
    else $error("bypass update flag timing wrong");

  orig_busy_bound_a: assert property (orig_busy_cnt_reg <= BUSY_MAX)
    else $error("originated update flag stuck");

  byp_busy_bound_a: assert property (byp_busy_cnt_reg <= BUSY_MAX)
    else $error("bypass update flag stuck");

  mapped_ok_a: assert property (acc && !pready && mapped |=> !pslverr)
    else $error("error response on a mapped register");

  busy_write_drop_a: assert property (orig_if.busy && wr && sel_orig |=> $stable(orig_ids_reg))
    else $error("write during update changed register");

  noflag_drop_a: assert property (wr && sel_byp && !flag_set |=> $stable(byp_ids_reg))
    else $error("flagless write changed register");

  orig_noflag_a: assert property (wr && sel_orig && !flag_set |=> $stable(orig_ids_reg))
    else $error("flagless originated write changed register");

  orig_held_a: assert property (!orig_if.busy |=> $stable(orig_if.active))
    else $error("originated tags moved without an update");

  byp_held_a: assert property (!byp_if.busy |=> $stable(byp_if.active))
    else $error("bypass tags moved without an update");

  orig_taken_a: assert property ($changed(orig_if.active) |->
      orig_if.active == orig_taken_reg)
    else $error("originated update applied a later value");

  byp_taken_a: assert property ($changed(byp_if.active) |->
      byp_if.active == byp_taken_reg)
    else $error("bypass update applied a later value");

  readback_new_a: assert property (byp_upd |=> byp_ids_reg == $past(byp_if.value))
    else $error("readback not immediate");

  orig_readback_a: assert property (orig_upd |=> orig_ids_reg == $past(orig_if.value))
    else $error("originated readback not immediate");

  reserved_zero_a: assert property ((orig_ids_reg[15:0] & ~PART_MASK) == 16'h0000 &&
      (orig_ids_reg[23:16] & ~GROUP_MASK) == 8'h00)
    else $error("reserved id bits set");

  byp_reserved_a: assert property ((byp_ids_reg[15:0] & ~PART_MASK) == 16'h0000 &&
      (byp_ids_reg[23:16] & ~GROUP_MASK) == 8'h00)
    else $error("reserved bypass id bits set");

  // ----------------------------------------------------------------------------
  // checks: traffic tags
  // ----------------------------------------------------------------------------

  upd_applies_ids_a: assert property (orig_upd |-> ##5
      originated_partition_id_out == $past(orig_if.value[15:0], 5))
    else $error("originated partition id not applied");

  group_applies_a: assert property (orig_upd |-> ##5
      originated_group_id_out == $past(orig_if.value[23:16], 5))
    else $error("originated group id not applied");

  byp_applies_a: assert property (byp_upd |-> ##4
      byp_if.active == $past(byp_if.value, 4))
    else $error("bypass ids not applied");

  bypass_select_a: assert property (use_bypass |=>
      client_partition_id_out == $past(byp_if.active[15:0]))
    else $error("bypass partition id wrong");

  bypass_group_a: assert property (use_bypass |=>
      client_group_id_out == $past(byp_if.active[23:16]))
    else $error("bypass group id wrong");

  stream_select_a: assert property (translation_enable_in && !ats_translated_in |=>
      client_group_id_out == $past(stream_group_id_in))
    else $error("stream group id not used");

  stream_part_a: assert property (translation_enable_in && !ats_translated_in |=>
      client_partition_id_out == $past(stream_partition_id_in))
    else $error("stream partition id not used");

  secure_stream_a: assert property (!nonsecure_in |=> !client_bypass_out)
    else $error("secure traffic took bypass tags");

  orig_update_c: cover property (orig_upd ##[1:8] !orig_if.busy);
  byp_update_c: cover property (byp_upd);
  busy_write_c: cover property (orig_if.busy && wr && sel_orig);
  slverr_c: cover property (pslverr);
  bypass_used_c: cover property (use_bypass ##1 client_bypass_out);
endmodule : partition_id_update_regs

/* File: verification/partition_id_update_regs_tb_top.sv */
// self-checking bench for the partition tag register bank
`timescale 1ns/1ps
`include "tag_regs_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module partition_id_update_regs_tb_top;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic translation_enable_in = 1'b0;
  logic ats_translated_in = 1'b0;
  logic ats_check_setting_in = 1'b0;
  logic nonsecure_in = 1'b0;
  logic [7:0] stream_group_id_in = 8'hA5;
  logic [15:0] stream_partition_id_in = 16'h5A3C;
  logic [7:0] originated_group_id_out;
  logic [15:0] originated_partition_id_out;
  logic [7:0] client_group_id_out;
  logic [15:0] client_partition_id_out;
  logic client_bypass_out;
  int n_mismatch = 0;
  int total_checks = 0;
  logic [31:0] rdata;
  logic err;

  partition_id_update_regs u_partition_id_update_regs (.sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .translation_enable_in(translation_enable_in), .ats_translated_in(ats_translated_in),
    .ats_check_setting_in(ats_check_setting_in), .nonsecure_in(nonsecure_in),
    .stream_group_id_in(stream_group_id_in), .stream_partition_id_in(stream_partition_id_in),
    .originated_group_id_out(originated_group_id_out),
    .originated_partition_id_out(originated_partition_id_out),
    .client_group_id_out(client_group_id_out), .client_partition_id_out(client_partition_id_out),
    .client_bypass_out(client_bypass_out));

  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) `CHK(pready, 1'b1)
  endtask : apb

  task rd_chk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rdata, e)
  endtask : rd_chk

  // polls the flag; bounded so a stuck flag shows as a mismatch, not a hang
  task wait_done(input logic [11:0] a);
    int i;
    i = 0;
    rdata = 32'h8000_0000;
    while (rdata[31] !== 1'b0 && i < 20) begin
      apb(1'b0, a, 32'h0000_0000);
      i++;
    end
    `CHK(rdata[31], 1'b0)
    repeat (3) @(posedge sys_clk_in);
  endtask : wait_done

  task cl(input logic te, ats, chk, ns, input logic [7:0] g, input logic [15:0] p);
    @(posedge sys_clk_in);
    translation_enable_in <= te;
    ats_translated_in <= ats;
    ats_check_setting_in <= chk;
    nonsecure_in <= ns;
    repeat (2) @(posedge sys_clk_in);
    `CHK({client_group_id_out, client_partition_id_out}, {g, p})
  endtask : cl

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_orig;
    apb(1'b1, `ORIG_TAG_OFFSET, 32'h80FF_FFFF);
    apb(1'b0, `ORIG_TAG_OFFSET, 32'h0000_0000);
    `CHK(rdata[30:0], 31'h000F_003F)
    rd_chk(`IDCAP_OFFSET, 32'h000F_0034);
    wait_done(`ORIG_TAG_OFFSET);
    apb(1'b1, `ORIG_TAG_OFFSET, 32'h8005_0021);
    wait_done(`ORIG_TAG_OFFSET);
    `CHK(originated_group_id_out, 8'h05)
    `CHK(originated_partition_id_out, 16'h0021)
    apb(1'b1, `ORIG_TAG_OFFSET, 32'h0003_0002);
    rd_chk(`ORIG_TAG_OFFSET, 32'h0005_0021);
    `CHK(originated_partition_id_out, 16'h0021)
    apb(1'b0, 12'h010, 32'h0000_0000);
    `CHK(err, 1'b1)
    $display("test originated tag done");
  endtask : t_orig

  task t_bypass;
    apb(1'b1, `BYP_TAG_OFFSET, 32'h8009_0013);
    // client traffic stays secure until the update is done
    wait_done(`BYP_TAG_OFFSET);
    cl(1'b0, 1'b0, 1'b0, 1'b1, 8'h09, 16'h0013);
    `CHK(client_bypass_out, 1'b1)
    cl(1'b1, 1'b0, 1'b0, 1'b1, 8'hA5, 16'h5A3C);
    `CHK(client_bypass_out, 1'b0)
    cl(1'b1, 1'b1, 1'b0, 1'b1, 8'h09, 16'h0013);
    cl(1'b1, 1'b1, 1'b1, 1'b1, 8'hA5, 16'h5A3C);
    $display("test bypass tag done");
  endtask : t_bypass

  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // the tests need well under a thousand cycles; this allows twenty times that
  initial begin
    #100000;
    n_mismatch++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    rd_chk(`ORIG_TAG_OFFSET, `TAG_RESET);
    rd_chk(`BYP_TAG_OFFSET, `TAG_RESET);
    `CHK(originated_partition_id_out, 16'h0000)
    $display("test reset done");
    t_orig;
    t_bypass;
    end_of_test;
  end
endmodule : partition_id_update_regs_tb_top
